// *** logic/synchronous_serial_port.sv ***
// synchronous serial port: master or slave shift engine with two word FIFOs
// assumes slave-side pins are already synchronous to ref_clk
`timescale 1ns/1ps
module synchronous_serial_port #(
  parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic [1:0] frame_format,
  input wire logic [3:0] data_size,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [ssp_pkg::DIV_W-1:0] prescale,
  input wire logic [ssp_pkg::DIV_W-1:0] divider,
  input wire logic clk_source_sel,
  input wire logic internal_precision_oscillator_tick,
  input wire logic slave_output_disable,
  input wire logic adv_mode,
  input wire logic frame_hold,
  input wire logic dma_tx_en,
  input wire logic dma_rx_en,
  input wire logic [ssp_pkg::NUM_INT-1:0] int_enable,
  input wire logic [ssp_pkg::NUM_INT-1:0] int_clear,
  input wire logic tx_write,
  input wire logic [ssp_pkg::WR_W-1:0] tx_wdata,
  input wire logic tx_end_of_frame,
  input wire logic rx_read,
  input wire logic sclk_in,
  input wire logic frame_select_in,
  input wire logic serial_in,
  output logic tx_full,
  output logic tx_empty,
  output logic rx_full,
  output logic rx_empty,
  output logic [ssp_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  output logic busy,
  output logic clk_source_current,
  output logic [ssp_pkg::NUM_INT-1:0] int_raw,
  output logic [ssp_pkg::NUM_INT-1:0] int_masked,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic sclk_out,
  output logic frame_select_pin,
  output logic serial_out,
  output logic serial_out_oe
);
  localparam int W = ssp_pkg::DATA_W;
  localparam int CW = $clog2(DEPTH) + 1;
  initial
  begin
    if (DEPTH < 2)
      $error("fifo depth too small");
  end
  fifo_if #(.W(W + 1), .CW(CW)) txf();
  fifo_if #(.W(W), .CW(CW)) rxf();
  ssp_fifo #(.W(W + 1), .DEPTH(DEPTH)) tx_fifo (.ref_clk(ref_clk), .reset(reset), .f(txf.owner));
  ssp_fifo #(.W(W), .DEPTH(DEPTH)) rx_fifo (.ref_clk(ref_clk), .reset(reset), .f(rxf.owner));

  ssp_pkg::eng_state_t state;
  logic [W-1:0] tx_sh;
  logic [W-1:0] rx_sh;
  logic [5:0] bit_cnt;
  logic eof;
  logic phase;
  logic sclk_prev;
  logic [2*ssp_pkg::DIV_W:0] half_cnt;
  logic [2*ssp_pkg::DIV_W:0] half_len;
  logic src_tick;
  logic half_tick;
  logic lead_ev;
  logic trail_ev;
  logic [5:0] last_bit;
  logic word_end;
  logic three_wire;

  // masking keeps the word to 4..16 bits whatever is asked for
  function automatic logic [W-1:0] size_mask(input logic [3:0] sz);
    logic [3:0] s;
    s = (sz < 4'(ssp_pkg::MIN_SIZE - 1)) ? 4'(ssp_pkg::MIN_SIZE - 1) : sz;
    size_mask = W'((17'h00002 << s) - 17'h00001);
  endfunction

  assign three_wire = frame_format == ssp_pkg::FMT_THREE_WIRE;
  // three-wire: command out, then as many bits in with output released
  assign last_bit = three_wire ? {1'b0, data_size, 1'b1} : {2'h0, data_size};

  // half bit clock is prescaler times (divider plus one) input clocks; a zero prescale acts as one
  assign half_len = (prescale == '0) ? 17'(divider) : 17'(prescale) * 17'(divider) + 17'(prescale) - 17'h00001;
  assign src_tick = clk_source_sel ? internal_precision_oscillator_tick : 1'b1;
  assign half_tick = src_tick && half_cnt >= half_len;

  always_ff @(posedge ref_clk)
  begin
    if (reset || state == ssp_pkg::st_idle)
      half_cnt <= '0;
    else if (src_tick)
      half_cnt <= half_tick ? '0 : half_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk_in;
  end

  // master edges come from the divider, slave edges from the outside clock
  always_comb
  begin
    if (master_mode)
    begin
      lead_ev = state == ssp_pkg::st_shift && half_tick && !phase;
      trail_ev = state == ssp_pkg::st_shift && half_tick && phase;
    end
    else
    begin
      lead_ev = state == ssp_pkg::st_shift && sclk_in != sclk_prev && sclk_in != cpol;
      trail_ev = state == ssp_pkg::st_shift && sclk_in != sclk_prev && sclk_in == cpol;
    end
  end
  assign word_end = trail_ev && bit_cnt == last_bit;

  logic can_start;
  logic hold_on;
  assign can_start = enable && !txf.empty && (master_mode || !frame_select_in);
  // frame hold keeps select asserted across bytes until an end-of-frame entry or an empty transmit FIFO
  assign hold_on = adv_mode && frame_hold && !eof && !txf.empty;
  assign txf.pop = (state == ssp_pkg::st_idle && can_start) || (word_end && master_mode && hold_on);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ssp_pkg::st_idle;
      tx_sh <= '0;
      rx_sh <= '0;
      bit_cnt <= '0;
      eof <= 1'b0;
      phase <= 1'b0;
    end
    else
    begin
      case (state)
        ssp_pkg::st_idle:
        begin
          phase <= 1'b0;
          bit_cnt <= '0;
          if (can_start)
          begin
            tx_sh <= txf.rdata[W-1:0];
            eof <= txf.rdata[W];
            state <= (master_mode && frame_format == ssp_pkg::FMT_SYNC) ? ssp_pkg::st_lead : ssp_pkg::st_shift;
          end
        end
        ssp_pkg::st_lead:
        begin
          // one bit clock of frame pulse before the first bit
          if (half_tick)
            phase <= !phase;
          if (half_tick && phase)
            state <= ssp_pkg::st_shift;
        end
        ssp_pkg::st_shift:
        begin
          if (!master_mode && (frame_select_in || !enable))
            state <= ssp_pkg::st_idle;
          else
          begin
            if (half_tick)
              phase <= !phase;
            if ((cpha ? trail_ev : lead_ev) && (!three_wire || bit_cnt > {2'h0, data_size}))
              rx_sh <= {rx_sh[W-2:0], serial_in};
            if (cpha ? (lead_ev && bit_cnt != '0) : (trail_ev && !word_end))
              tx_sh <= {tx_sh[W-2:0], 1'b0};
            if (trail_ev)
              bit_cnt <= bit_cnt + 1'b1;
            if (word_end)
            begin
              bit_cnt <= '0;
              if (!master_mode)
                state <= ssp_pkg::st_idle;
              else if (hold_on)
              begin
                tx_sh <= txf.rdata[W-1:0];
                eof <= txf.rdata[W];
              end
              else
                state <= ssp_pkg::st_gap;
            end
          end
        end
        ssp_pkg::st_gap:
        begin
          // select released for one full bit clock between words
          if (half_tick)
            phase <= !phase;
          if (half_tick && phase)
            state <= ssp_pkg::st_idle;
        end
        default:
          state <= ssp_pkg::st_idle;
      endcase
    end
  end

  // advanced writes keep the low byte only
  assign txf.push = tx_write && !txf.full;
  assign txf.wdata = adv_mode ? {tx_end_of_frame, {(W - ssp_pkg::ADV_BYTE_W){1'b0}}, tx_wdata[ssp_pkg::ADV_BYTE_W-1:0]}
                              : {1'b0, tx_wdata[W-1:0]};
  assign rxf.push = word_end && !rxf.full;
  // leading-edge sampling already holds the last bit; trailing-edge sampling takes it this cycle
  assign rxf.wdata = (cpha ? {rx_sh[W-2:0], serial_in} : rx_sh) & size_mask(data_size);
  assign rxf.pop = rx_read;

  // pins, all from flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sclk_out <= 1'b0;
      frame_select_pin <= 1'b1;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      sclk_out <= cpol ^ (state == ssp_pkg::st_shift && phase != (half_tick && master_mode));
      if (frame_format == ssp_pkg::FMT_SYNC)
        frame_select_pin <= state == ssp_pkg::st_lead && master_mode;
      else
        frame_select_pin <= !(master_mode && state == ssp_pkg::st_shift);
      serial_out <= tx_sh[data_size];
      if (master_mode)
        serial_out_oe <= state == ssp_pkg::st_shift && !(three_wire && bit_cnt > {2'h0, data_size});
      else
        serial_out_oe <= !frame_select_in && !slave_output_disable && enable;
    end
  end

  // status, dma, interrupts
  logic [ssp_pkg::NUM_INT-1:0] ev;
  always_comb
  begin
    ev = '0;
    ev[ssp_pkg::INT_TX_HALF] = txf.count <= CW'(DEPTH / 2);
    ev[ssp_pkg::INT_RX_HALF] = rxf.count >= CW'(DEPTH / 2);
    ev[ssp_pkg::INT_RX_OVERRUN] = word_end && rxf.full;
    ev[ssp_pkg::INT_TX_DONE] = state == ssp_pkg::st_gap && half_tick && phase && txf.empty;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      int_raw <= ssp_pkg::INT_RESET;
    else
      // sticky bits: a new event wins over a clear in the same cycle
      int_raw <= ev | (int_raw & ssp_pkg::INT_STICKY & ~int_clear);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      int_masked <= '0;
    else
      int_masked <= (ev | (int_raw & ssp_pkg::INT_STICKY & ~int_clear)) & int_enable;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end
    else
    begin
      dma_tx_req <= dma_tx_en && (txf.count + CW'(txf.push) - CW'(txf.pop)) <= CW'(DEPTH / 2);
      dma_rx_req <= dma_rx_en && !(rxf.empty && !rxf.push) && !(rxf.pop && rxf.count == CW'(1));
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_data <= '0;
      rx_valid <= 1'b0;
      busy <= 1'b0;
      clk_source_current <= 1'b0;
    end
    else
    begin
      rx_valid <= rx_read && !rxf.empty;
      if (rx_read && !rxf.empty)
        rx_data <= rxf.rdata;
      busy <= state != ssp_pkg::st_idle || !txf.empty;
      // the reported source follows the selection only while idle; src_tick follows clk_source_sel at once, even mid-frame
      if (state == ssp_pkg::st_idle)
        clk_source_current <= clk_source_sel;
    end
  end

  assign tx_full = txf.full;
  assign tx_empty = txf.empty;
  assign rx_full = rxf.full;
  assign rx_empty = rxf.empty;
endmodule

// *** logic/ssp_pkg.sv ***
// constants, field layouts and enumerations of the synchronous serial port
// assumes one clock domain and a user that drives the configuration ports directly
// Operation
// - SPI frames, the synchronous-frame format with a leading frame pulse, and a three-wire command/response format are selectable.
// - Frame size is programmable from 4 to 16 bits, both included.
// - Received bits are shifted into parallel words and queued words are shifted out one bit per serial clock.
// - Transmit and receive paths each have their own FIFO of eight 16-bit entries.
// - The port runs as master making clock and frame select, or as slave following an outside master.
// - As slave an option keeps the serial data output undriven so several slaves can share the lines.
// - The master serial clock comes from the input clock through a prescaler and then a bit-rate divider.
// - The bit clock source is selectable between the system clock and the internal oscillator and the selection is readable.
// - Transmit and receive DMA requests exist and are enabled separately.
// - Interrupt sources can each be enabled and disabled, the sticky overrun and transmit-done sources can be cleared, and raw and masked status are both readable.
// - In advanced mode an entry may mark end of frame, after which frame select stays deasserted for at least one serial clock.
// - An advanced-mode write keeps only the low 8 bits and ignores the upper 24.
// - In advanced mode frame select drops for one serial clock after every byte, unless frame hold keeps it until end of frame or an empty transmit FIFO.
package ssp_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int MIN_SIZE = 4;
  localparam int MAX_SIZE = 16;
  localparam int ADV_BYTE_W = 8;
  localparam int WR_W = 32;
  localparam int DIV_W = 8;
  localparam int NUM_INT = 4;
  // interrupt field positions
  localparam int INT_TX_HALF = 0;
  localparam int INT_RX_HALF = 1;
  localparam int INT_RX_OVERRUN = 2;
  localparam int INT_TX_DONE = 3;
  localparam logic [NUM_INT-1:0] INT_STICKY = 4'hC;
  localparam logic [NUM_INT-1:0] INT_RESET = 4'h0;
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_SYNC = 2'h1;
  localparam logic [1:0] FMT_THREE_WIRE = 2'h2;
  typedef enum logic [2:0] {st_idle, st_lead, st_shift, st_gap} eng_state_t;
endpackage

// *** logic/fifo_if.sv ***
// push/pop port of one word FIFO
// assumes the FIFO and its user share one clock
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 16, parameter int CW = 4);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [CW-1:0] count;
  modport owner (input push, input wdata, input pop, output rdata, output full, output empty, output count);
  modport user (output push, output wdata, output pop, input rdata, input full, input empty, input count);
endinterface

// *** logic/ssp_fifo.sv ***
// first-in first-out store for the serial port
// a push given while full and a pop given while empty are ignored
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  fifo_if.owner f
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign f.rdata = mem[rd_ptr];
  always_ff @(posedge ref_clk)
  begin
    if (do_push)
      mem[wr_ptr] <= f.wdata;
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      f.count <= '0;
      f.full <= 1'b0;
      f.empty <= 1'b1;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(do_push);
      rd_ptr <= rd_ptr + AW'(do_pop);
      if (do_push != do_pop)
      begin
        f.count <= do_push ? f.count + 1'b1 : f.count - 1'b1;
        f.full <= do_push && (f.count == $bits(f.count)'(DEPTH - 1));
        f.empty <= do_pop && (f.count == $bits(f.count)'(1));
      end
    end
  end
endmodule

// *** verif/ssp_chk.sv ***
// concurrent checks on the serial port top ports
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
module ssp_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic master_mode,
  input wire logic [1:0] frame_format,
  input wire logic [7:0] prescale,
  input wire logic [7:0] divider,
  input wire logic clk_source_sel,
  input wire logic slave_output_disable,
  input wire logic dma_tx_en,
  input wire logic dma_rx_en,
  input wire logic [3:0] int_enable,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic tx_empty,
  input wire logic rx_empty,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic [3:0] int_raw,
  input wire logic [3:0] int_masked,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req,
  input wire logic frame_select_pin,
  input wire logic serial_out_oe
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  int hi_cnt;
  int half;
  // only valid on the system clock; ticks stretch the gap
  assign half = (prescale == 8'h00 ? 1 : int'(prescale)) * (int'(divider) + 1);
  always_ff @(posedge ref_clk)
  begin
    if (reset || !frame_select_pin)
      hi_cnt <= 0;
    else
      hi_cnt <= hi_cnt + 1;
  end
  chk_reset_idle: assert property (
    $fell(reset) |-> tx_empty && rx_empty && !busy && frame_select_pin && int_masked == 4'h0)
    else $error("outputs not idle after reset");
  chk_frame_gap: assert property (
    $fell(frame_select_pin) && master_mode && frame_format == 2'h0 && !clk_source_sel |-> hi_cnt >= 2 * half)
    else $error("frame select gap shorter than one bit clock");
  chk_masked_status: assert property (
    $stable(int_enable) |-> int_masked == (int_raw & int_enable))
    else $error("masked status differs from raw and enable");
  chk_dma_tx_off: assert property (
    !dma_tx_en [*2] |-> !dma_tx_req)
    else $error("transmit request while disabled");
  chk_dma_rx_off: assert property (
    !dma_rx_en [*2] |-> !dma_rx_req)
    else $error("receive request while disabled");
  chk_slave_quiet: assert property (
    (!master_mode && slave_output_disable) [*2] |-> !serial_out_oe)
    else $error("slave drives output while disabled");
  chk_rx_answer: assert property (
    rx_read |=> rx_valid == !$past(rx_empty))
    else $error("read answer wrong");
  chk_tx_take: assert property (
    tx_write && tx_empty |=> !tx_empty)
    else $error("write into empty fifo lost");
  cover property ($fell(frame_select_pin) && master_mode);
  cover property ($rose(int_raw[2]));
  cover property (dma_rx_req && dma_tx_req);
endmodule

// *** verif/ssp_peer.sv ***
// far-side serial device: clock mode 0 slave that records and answers
// assumes master pins change on ref_clk edges
`timescale 1ns/1ps
module ssp_peer (
  input wire logic ref_clk,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic [15:0] reply,
  input wire logic [4:0] bits,
  output logic miso,
  output logic [15:0] heard
);
  logic sclk_d;
  logic [15:0] sh;
  initial miso = 1'b0;
  always @(posedge ref_clk)
  begin
    sclk_d <= sclk;
    if (select_n)
    begin
      sh <= reply << (5'd16 - bits);
      miso <= ~miso; // released line, no stale level
    end
    else
    begin
      miso <= sh[15];
      if (sclk && !sclk_d)
        heard <= {heard[14:0], mosi};
      if (!sclk && sclk_d)
        sh <= {sh[14:0], 1'b0};
    end
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the serial port, master against a mode 0 peer
// assumes inputs driven at the falling edge
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, reset, enable, master_mode, cpol, cpha, clk_source_sel, slave_output_disable;
  logic adv_mode, frame_hold, dma_tx_en, dma_rx_en, tx_write, tx_end_of_frame, rx_read;
  logic sclk_in, frame_select_in, serial_in, internal_precision_oscillator_tick;
  logic tx_full, tx_empty, rx_full, rx_empty, rx_valid, busy, clk_source_current;
  logic dma_tx_req, dma_rx_req, sclk_out, frame_select_pin, serial_out, serial_out_oe;
  logic [1:0] frame_format;
  logic [3:0] data_size, int_enable, int_clear, int_raw, int_masked;
  logic [7:0] prescale, divider;
  logic [31:0] tx_wdata;
  logic [15:0] rx_data, reply, heard;
  logic [4:0] bits;
  int err_count = 0;
  int comparisons = 0;
  int rises = 0;
  int cyc = 0;
  int per = 0;
  int last_rise = 0;
  synchronous_serial_port dut (.*);
  ssp_peer peer (.ref_clk(ref_clk), .sclk(sclk_out), .select_n(frame_select_pin), .mosi(serial_out),
    .reply(reply), .bits(bits), .miso(serial_in), .heard(heard));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if ($rose(frame_select_pin))
      rises <= rises + 1;
    if ($rose(sclk_out))
    begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end
  always @(negedge ref_clk)
    internal_precision_oscillator_tick <= (cyc % 3 == 0);
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset;
    reset = 1'b1;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    repeat (20) @(negedge ref_clk);
  endtask
  task automatic push(logic [31:0] d, logic eof);
    @(negedge ref_clk);
    tx_write = 1'b1;
    tx_wdata = d;
    tx_end_of_frame = eof;
    @(negedge ref_clk);
    tx_write = 1'b0;
  endtask
  task automatic pop(logic [15:0] exp);
    @(negedge ref_clk);
    rx_read = 1'b1;
    @(negedge ref_clk);
    rx_read = 1'b0;
    chk("rx_valid", 1, rx_valid);
    chk("rx_data", exp, rx_data);
  endtask
  // bounded wait for the engine to drain and the select to settle
  task automatic wait_done;
    int i;
    i = 0;
    repeat (3) @(negedge ref_clk);
    while ((busy !== 1'b0 || tx_empty !== 1'b1 || (frame_format != 2'h1 && frame_select_pin !== 1'b1)) && i < 3000)
    begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 3000)
    begin
      err_count++;
      $display("MISMATCH idle wait expected done seen busy");
      tally_and_finish();
    end
  endtask
  task automatic s_sizes;
    int sz[3] = '{4, 16, 8};
    logic [15:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = 16'hFFFF >> (16 - sz[i]);
      data_size = 4'(sz[i] - 1);
      bits = 5'(sz[i]);
      reply = 16'h3C96;
      push(32'h0000A5C3, 1'b0);
      wait_done();
      chk("heard", 16'hA5C3 & m, heard & m);
      pop(16'h3C96 & m);
    end
  endtask
  task automatic s_formats;
    for (int f = 1; f < 3; f++)
    begin
      frame_format = 2'(f);
      rises = 0;
      push(32'h00000096, 1'b0);
      wait_done();
      chk("format frame", 1, rises > 0);
      chk("format rx_empty", 0, rx_empty);
    end
    frame_format = 2'h0;
    do_reset();
  endtask
  task automatic s_fifo;
    reply = 16'h005A;
    enable = 1'b0;
    for (int i = 0; i < 9; i++)
      push(32'h10 + i, 1'b0);
    chk("tx_full", 1, tx_full);
    chk("tx level flag", 0, int_raw[0]);
    enable = 1'b1;
    wait_done();
    chk("last sent", 8'h17, heard[7:0]);
    chk("rx full flags", 2'b11, {rx_full, int_raw[1]});
    {dma_tx_en, dma_rx_en} = 2'b11;
    repeat (2) @(negedge ref_clk);
    chk("dma requests", 2'b11, {dma_tx_req, dma_rx_req});
    {dma_tx_en, dma_rx_en} = 2'b00;
    int_enable = 4'h4;
    push(32'h20, 1'b0);
    wait_done();
    chk("overrun raw masked", 2'b11, {int_raw[2], int_masked[2]});
    int_clear = 4'h4;
    @(negedge ref_clk);
    int_clear = 4'h0;
    @(negedge ref_clk);
    chk("overrun cleared", 0, int_raw[2]);
    int_enable = 4'h0;
    repeat (8) pop(16'h005A);
    chk("rx_empty", 1, rx_empty);
  endtask
  task automatic s_adv;
    adv_mode = 1'b1; // 8-bit clock mode 0 already set
    for (int h = 1; h >= 0; h--)
    begin
      frame_hold = h[0];
      rises = 0;
      push(32'hFFFFFF5A, 1'b0);
      chk("room for end", 0, tx_full);
      push(32'h123456C3, 1'b1);
      wait_done();
      chk("low bytes only", 16'h5AC3, heard);
      chk("select releases", h ? 1 : 2, rises);
    end
    {adv_mode, frame_hold} = 2'b00;
    do_reset();
  endtask
  task automatic s_slave;
    {master_mode, frame_select_in, slave_output_disable} = 3'b001;
    repeat (3) @(negedge ref_clk);
    chk("oe disabled", 0, serial_out_oe);
    slave_output_disable = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("oe selected", 1, serial_out_oe);
    {master_mode, frame_select_in} = 2'b11;
    do_reset();
  endtask
  task automatic s_clock;
    {prescale, divider} = 16'h0202;
    push(32'h00000033, 1'b0);
    wait_done();
    chk("bit period", 12, per);
    clk_source_sel = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("source", 1, clk_source_current);
    push(32'h000000CC, 1'b0);
    wait_done();
    chk("tick word", 8'hCC, heard[7:0]);
  endtask
  initial
  begin
    {enable, master_mode, frame_select_in, reset} = 4'hF;
    {cpol, cpha, clk_source_sel, slave_output_disable, adv_mode, frame_hold} = 6'h00;
    {dma_tx_en, dma_rx_en, tx_write, tx_end_of_frame, rx_read, sclk_in} = 6'h00;
    {frame_format, data_size, int_enable, int_clear} = 14'h0700;
    {prescale, divider, tx_wdata} = 48'h020100000000;
    {reply, bits} = {16'h005A, 5'h08};
    do_reset();
    chk("reset outputs", 8'hC0, {tx_empty, rx_empty, tx_full, busy, int_masked});
    s_sizes();
    s_formats();
    s_fifo();
    s_adv();
    s_slave();
    s_clock();
    tally_and_finish();
  end
endmodule
bind synchronous_serial_port ssp_chk chk (.*);
